// File: src/pic_ctrl.sv
// What this block does
// RULE1 - Five sources with fixed priority: high ext, counter A, counter B, tick, low ext.
// RULE2 - Accepted source loads entry address 002, 006, 008, 00A or 00C.
// RULE3 - Each source owns a request latch at index 5, 3, 2, 1, 0.
// RULE4 - High ext needs master only; others use enable bits 2, 1, 1, 0.
// RULE5 - Source enable mask is four bits, one enables, cleared on reset.
// RULE6 - Enable mask is read and written only by one accumulator exchange.
// RULE7 - Master enable blocks all interrupts when zero; cleared on reset.
// RULE8 - Latch instruction mask: zero clears a latch; variants set or clear master.
// RULE9 - No instruction can set a request latch.
// RULE10 - Accepted latch is cleared; all latches clear on reset.
// RULE11 - Highest priority enabled pending request is serviced first.
// RULE12 - Acknowledge takes two instruction cycles after the current instruction ends.
// RULE13 - Ack pushes PC and flags, loads vector, sets branch flag, clears master, clears latch.
// RULE14 - Return from service restores PC and flags and sets master enable.
// RULE15 - A request stays latched until accepted, reset or cleared by instruction.
// RULE16 - Service code saves the accumulator and other registers itself.
// RULE17 - Nesting: software sets master enable and gates high ext itself.
// RULE18 - External latches set on a falling edge of their pins.
// RULE19 - Carry, zero, branch and general flags are pushed and popped with the PC.
// RULE20 - Disabled pending requests stay latched and are reconsidered later.
// RULE21 - Arbiter sees only latched and enabled requests; gives vector and index.
`timescale 1ns/1ns
module pic_ctrl
  import pic_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire logic                  ext_irq_high,
  input  wire logic                  ext_irq_low,
  input  wire logic                  counter_a_overflow_irq,
  input  wire logic                  counter_b_overflow_irq,
  input  wire logic                  interval_tick_irq,
  input  wire logic                  instr_boundary,
  input  wire logic                  exchange_with_accumulator,
  input  wire logic [ENA_WIDTH-1:0]  acc_in,
  input  wire logic                  latch_clear,
  input  wire logic                  latch_clear_with_enable,
  input  wire logic                  latch_clear_with_disable,
  input  wire logic [NUM_LATCH-1:0]  latch_keep_mask,
  input  wire logic                  return_from_service,
  input  wire logic [PC_WIDTH-1:0]   cpu_pc,
  input  wire logic [FLAG_WIDTH-1:0] cpu_flags,
  input  wire logic [PC_WIDTH-1:0]   stack_pc,
  input  wire logic [FLAG_WIDTH-1:0] stack_flags,
  output logic [ENA_WIDTH-1:0]       acc_out,
  output logic                       ack_busy,
  output logic                       push_req,
  output logic [PC_WIDTH-1:0]        push_pc,
  output logic [FLAG_WIDTH-1:0]      push_flags,
  output logic                       pc_load,
  output logic [PC_WIDTH-1:0]        pc_load_value,
  output logic                       flags_load,
  output logic [FLAG_WIDTH-1:0]      flags_load_value,
  output logic                       pop_req,
  output logic                       master_irq_enable,
  output logic [ENA_WIDTH-1:0]       source_enable_mask,
  output logic [NUM_LATCH-1:0]       request_latch
);
  logic [2:0]             ext_high_sync_q;
  logic [2:0]             ext_low_sync_q;
  logic [INSTR_CNT_WIDTH-1:0] div_q;
  logic                   icycle_tick;
  logic [NUM_LATCH-1:0]   latch_q;
  logic [NUM_LATCH-1:0]   latch_d;
  logic [NUM_LATCH-1:0]   req_set;
  logic [NUM_LATCH-1:0]   enabled;
  logic [NUM_LATCH-1:0]   pend;
  logic [NUM_LATCH-1:0]   instr_clr;
  logic [NUM_LATCH-1:0]   ack_clr;
  logic                   master_q;
  logic                   master_d;
  logic [ENA_WIDTH-1:0]   ena_q;
  logic                   found;
  logic [2:0]             win_idx;
  logic [PC_WIDTH-1:0]    win_vec;
  logic [2:0]             idx_q;
  pic_state_t             state_q;
  pic_state_t             state_d;
  logic                   accept;
  logic                   ack_done;
  logic [ENA_WIDTH-1:0]   acc_out_q;
  logic                   push_q;
  logic [PC_WIDTH-1:0]    push_pc_q;
  logic [FLAG_WIDTH-1:0]  push_flags_q;
  logic                   pc_load_q;
  logic [PC_WIDTH-1:0]    pc_val_q;
  logic                   fl_load_q;
  logic [FLAG_WIDTH-1:0]  fl_val_q;
  logic                   pop_q;

  // Two flops cross the pins into the clock domain; the third gives the edge.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_high_sync_q <= 3'h7;
      ext_low_sync_q  <= 3'h7;
    end else begin
      ext_high_sync_q <= {ext_high_sync_q[1:0], ext_irq_high};
      ext_low_sync_q  <= {ext_low_sync_q[1:0], ext_irq_low};
    end
  end

  // Eight clocks form one instruction cycle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign icycle_tick = (div_q == INSTR_LAST_CNT);

  assign req_set[IDX_EXT_HIGH] = ext_high_sync_q[2] & ~ext_high_sync_q[1];  // [RULE18]
  assign req_set[IDX_EXT_LOW]  = ext_low_sync_q[2] & ~ext_low_sync_q[1];    // [RULE18]
  assign req_set[IDX_CNT_A]    = counter_a_overflow_irq;                    // [RULE3]
  assign req_set[IDX_CNT_B]    = counter_b_overflow_irq;
  assign req_set[IDX_TICK]     = interval_tick_irq;
  assign req_set[4]            = 1'b0;

  assign enabled[IDX_EXT_HIGH] = master_q;                                  // [RULE4] [RULE7]
  assign enabled[IDX_CNT_A]    = master_q & ena_q[ENA_CNT_A];               // [RULE4]
  assign enabled[IDX_CNT_B]    = master_q & ena_q[ENA_SHARED];              // [RULE4]
  assign enabled[IDX_TICK]     = master_q & ena_q[ENA_SHARED];
  assign enabled[IDX_EXT_LOW]  = master_q & ena_q[ENA_EXT_LOW];
  assign enabled[4]            = 1'b0;
  assign pend = latch_q & enabled;                                          // [RULE21] [RULE20]

  pic_arbiter u_arb (
    .pend    (pend),
    .found   (found),
    .win_idx (win_idx),
    .win_vec (win_vec)
  );

  assign instr_clr = (latch_clear | latch_clear_with_enable | latch_clear_with_disable)
                     ? ~latch_keep_mask : '0;                               // [RULE8]
  assign accept   = (state_q == PIC_IDLE) & instr_boundary & found;         // [RULE12]
  assign ack_done = (state_q == PIC_ACK2) & icycle_tick;
  assign ack_clr  = ack_done ? (6'h01 << idx_q) : '0;                       // [RULE10] [RULE13]
  // A new request wins over a clear in the same cycle; only hardware sets.
  assign latch_d  = (latch_q & ~instr_clr & ~ack_clr) | req_set;            // [RULE9] [RULE15]

  always_comb begin
    master_d = master_q;
    if (latch_clear_with_enable | return_from_service) begin
      master_d = 1'b1;                                                      // [RULE8] [RULE14]
    end
    if (latch_clear_with_disable) begin
      master_d = 1'b0;
    end
    if (accept) begin
      master_d = 1'b0;                                                      // [RULE13]
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      PIC_IDLE: begin
        if (accept) begin
          state_d = PIC_ACK1;
        end
      end
      PIC_ACK1: begin
        if (icycle_tick) begin
          state_d = PIC_ACK2;
        end
      end
      PIC_ACK2: begin
        if (icycle_tick) begin
          state_d = PIC_IDLE;
        end
      end
      default: state_d = PIC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      latch_q  <= LATCH_RESET;                                              // [RULE10]
      master_q <= MASTER_RESET;                                             // [RULE7]
      ena_q    <= ENA_RESET;                                                // [RULE5]
      state_q  <= PIC_IDLE;
      idx_q    <= 3'h0;
    end else begin
      latch_q  <= latch_d;
      master_q <= master_d;
      state_q  <= state_d;
      if (exchange_with_accumulator) begin
        ena_q <= acc_in;                                                    // [RULE6]
      end
      if (accept) begin
        idx_q <= win_idx;
      end
    end
  end

  // Sequencer strobes: push and vector load at the start, latch clear at the end.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_out_q    <= '0;
      push_q       <= 1'b0;
      push_pc_q    <= '0;
      push_flags_q <= '0;
      pc_load_q    <= 1'b0;
      pc_val_q     <= '0;
      fl_load_q    <= 1'b0;
      fl_val_q     <= '0;
      pop_q        <= 1'b0;
    end else begin
      if (exchange_with_accumulator) begin
        acc_out_q <= ena_q;                                                 // [RULE6]
      end
      push_q       <= accept;                                               // [RULE13]
      pc_load_q    <= accept | return_from_service;
      fl_load_q    <= accept | return_from_service;
      pop_q        <= return_from_service;                                  // [RULE14]
      if (accept) begin
        push_pc_q    <= cpu_pc;
        push_flags_q <= cpu_flags;                                          // [RULE19]
        pc_val_q     <= win_vec;                                            // [RULE2]
        fl_val_q     <= cpu_flags | (4'h1 << FLAG_BRANCH);                  // [RULE13]
      end else if (return_from_service) begin
        pc_val_q <= stack_pc;                                               // [RULE14]
        fl_val_q <= stack_flags;                                            // [RULE19]
      end
    end
  end

  assign acc_out            = acc_out_q;
  assign ack_busy           = (state_q != PIC_IDLE);
  assign push_req           = push_q;
  assign push_pc            = push_pc_q;
  assign push_flags         = push_flags_q;
  assign pc_load            = pc_load_q;
  assign pc_load_value      = pc_val_q;
  assign flags_load         = fl_load_q;
  assign flags_load_value   = fl_val_q;
  assign pop_req            = pop_q;
  assign master_irq_enable  = master_q;
  assign source_enable_mask = ena_q;
  assign request_latch      = latch_q;
endmodule

// File: inc/pic_pkg.sv
package pic_pkg;
  localparam int unsigned NUM_LATCH         = 6;
  localparam int unsigned ENA_WIDTH         = 4;
  localparam int unsigned PC_WIDTH          = 12;
  localparam int unsigned FLAG_WIDTH        = 4;
  localparam int unsigned CLK_PER_INSTR     = 8;
  localparam int unsigned INSTR_CNT_WIDTH   = 3;
  localparam logic [2:0]  INSTR_LAST_CNT    = 3'h7;
  localparam int unsigned ACK_CYCLES        = 2;
  localparam logic [ENA_WIDTH-1:0] ENA_RESET = 4'h0;
  localparam logic [5:0]  LATCH_RESET       = 6'h00;
  localparam logic        MASTER_RESET      = 1'b0;
  localparam int unsigned IDX_EXT_HIGH      = 5;
  localparam int unsigned IDX_CNT_A         = 3;
  localparam int unsigned IDX_CNT_B         = 2;
  localparam int unsigned IDX_TICK          = 1;
  localparam int unsigned IDX_EXT_LOW       = 0;
  localparam int unsigned ENA_CNT_A         = 2;
  localparam int unsigned ENA_SHARED        = 1;
  localparam int unsigned ENA_EXT_LOW       = 0;
  localparam logic [PC_WIDTH-1:0] VEC_EXT_HIGH = 12'h002;
  localparam logic [PC_WIDTH-1:0] VEC_CNT_A    = 12'h006;
  localparam logic [PC_WIDTH-1:0] VEC_CNT_B    = 12'h008;
  localparam logic [PC_WIDTH-1:0] VEC_TICK     = 12'h00a;
  localparam logic [PC_WIDTH-1:0] VEC_EXT_LOW  = 12'h00c;
  localparam int unsigned FLAG_CARRY        = 3;
  localparam int unsigned FLAG_ZERO         = 2;
  localparam int unsigned FLAG_BRANCH       = 1;
  localparam int unsigned FLAG_GENERAL      = 0;
  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_ACK1 = 2'b01,
    PIC_ACK2 = 2'b10
  } pic_state_t;
endpackage

// File: src/pic_arbiter.sv
`timescale 1ns/1ns
module pic_arbiter
  import pic_pkg::*;
(
  input  wire logic [NUM_LATCH-1:0] pend,
  output logic                      found,
  output logic [2:0]                win_idx,
  output logic [PC_WIDTH-1:0]       win_vec
);
  // Fixed priority: high external, counter A, counter B, tick, low external.
  always_comb begin
    found   = 1'b1;
    win_idx = 3'h0;
    win_vec = VEC_EXT_LOW;
    if (pend[IDX_EXT_HIGH]) begin  // [RULE1] [RULE11]
      win_idx = 3'h5;
      win_vec = VEC_EXT_HIGH;       // [RULE2]
    end else if (pend[IDX_CNT_A]) begin
      win_idx = 3'h3;
      win_vec = VEC_CNT_A;
    end else if (pend[IDX_CNT_B]) begin
      win_idx = 3'h2;
      win_vec = VEC_CNT_B;
    end else if (pend[IDX_TICK]) begin
      win_idx = 3'h1;
      win_vec = VEC_TICK;
    end else if (pend[IDX_EXT_LOW]) begin
      win_idx = 3'h0;
      win_vec = VEC_EXT_LOW;
    end else begin
      found = 1'b0;
    end
  end
endmodule

// File: test/pic_ctrl_monitor.sv
`timescale 1ns/1ns
module pic_ctrl_monitor
  import pic_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        instr_boundary,
  input wire logic        exchange_with_accumulator,
  input wire logic [3:0]  acc_in,
  input wire logic        latch_clear,
  input wire logic        latch_clear_with_enable,
  input wire logic        latch_clear_with_disable,
  input wire logic [5:0]  latch_keep_mask,
  input wire logic        return_from_service,
  input wire logic [11:0] cpu_pc,
  input wire logic [3:0]  cpu_flags,
  input wire logic [11:0] stack_pc,
  input wire logic [3:0]  stack_flags,
  input wire logic [3:0]  acc_out,
  input wire logic        ack_busy,
  input wire logic        push_req,
  input wire logic [11:0] push_pc,
  input wire logic [3:0]  push_flags,
  input wire logic        pc_load,
  input wire logic [11:0] pc_load_value,
  input wire logic        flags_load,
  input wire logic [3:0]  flags_load_value,
  input wire logic        pop_req,
  input wire logic        master_irq_enable,
  input wire logic [3:0]  source_enable_mask,
  input wire logic [5:0]  request_latch
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic        m;
  logic        acc;
  logic        clr;
  logic [5:0]  pend;
  logic [11:0] vec;
  assign m    = master_irq_enable;
  assign clr  = latch_clear | latch_clear_with_enable | latch_clear_with_disable;
  assign pend = request_latch & {m, 1'b0, m & source_enable_mask[2],
                                 {2{m & source_enable_mask[1]}}, m & source_enable_mask[0]};
  assign vec  = pend[5] ? VEC_EXT_HIGH : pend[3] ? VEC_CNT_A : pend[2] ? VEC_CNT_B :
                pend[1] ? VEC_TICK : VEC_EXT_LOW;
  assign acc  = instr_boundary & ~ack_busy & (|pend);
  property p_reset; $fell(srst) |-> !m && source_enable_mask == 4'h0 && request_latch == 6'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_accept; acc |=> push_req && pc_load && flags_load && !m
    && flags_load_value[FLAG_BRANCH] && ack_busy
    ##1 ack_busy [*7] ##[1:16] !ack_busy; endproperty
  a_accept: assert property (p_accept) else $error("acknowledge wrong");
  property p_vec; push_req |-> $past(acc) && pc_load_value == $past(vec)
    && push_pc == $past(cpu_pc) && push_flags == $past(cpu_flags); endproperty
  a_vec: assert property (p_vec) else $error("entry or save wrong");
  property p_ret; return_from_service && !latch_clear_with_disable && !acc |=> m && pop_req;
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_pop; return_from_service && !acc |=> pc_load && flags_load
    && pc_load_value == $past(stack_pc) && flags_load_value == $past(stack_flags); endproperty
  a_pop: assert property (p_pop) else $error("restore wrong");
  property p_xch; exchange_with_accumulator |=> source_enable_mask == $past(acc_in)
    && acc_out == $past(source_enable_mask); endproperty
  a_xch: assert property (p_xch) else $error("exchange wrong");
  property p_clr; clr && !ack_busy && !acc |=>
    request_latch == ($past(request_latch) & $past(latch_keep_mask)); endproperty
  a_clr: assert property (p_clr) else $error("latch clear wrong");
  property p_dis; latch_clear_with_disable |=> !m; endproperty
  a_dis: assert property (p_dis) else $error("disable wrong");
  property p_en; latch_clear_with_enable && !latch_clear_with_disable && !acc |=> m; endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_hold; !$past(srst) && !$past(ack_busy) && !$past(clr) |->
    (request_latch | ~$past(request_latch)) == 6'h3f; endproperty
  a_hold: assert property (p_hold) else $error("request lost");
endmodule
bind pic_ctrl pic_ctrl_monitor pic_ctrl_monitor_inst (
  .ref_clk(ref_clk), .srst(srst), .instr_boundary(instr_boundary),
  .exchange_with_accumulator(exchange_with_accumulator), .acc_in(acc_in),
  .latch_clear(latch_clear), .latch_clear_with_enable(latch_clear_with_enable),
  .latch_clear_with_disable(latch_clear_with_disable), .latch_keep_mask(latch_keep_mask),
  .return_from_service(return_from_service), .cpu_pc(cpu_pc), .cpu_flags(cpu_flags),
  .stack_pc(stack_pc), .stack_flags(stack_flags), .acc_out(acc_out), .ack_busy(ack_busy),
  .push_req(push_req), .push_pc(push_pc), .push_flags(push_flags), .pc_load(pc_load),
  .pc_load_value(pc_load_value), .flags_load(flags_load),
  .flags_load_value(flags_load_value), .pop_req(pop_req),
  .master_irq_enable(master_irq_enable), .source_enable_mask(source_enable_mask),
  .request_latch(request_latch)
);

// File: test/pic_cpu_model.sv
`timescale 1ns/1ns
module pic_cpu_model
  import pic_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        push_req,
  input  wire logic [11:0] push_pc,
  input  wire logic [3:0]  push_flags,
  input  wire logic        pop_req,
  output logic             instr_boundary,
  output logic [11:0]      cpu_pc,
  output logic [3:0]       cpu_flags,
  output logic [11:0]      stack_pc,
  output logic [3:0]       stack_flags
);
  logic [15:0] stk[$];
  logic [2:0]  cnt;
  initial begin
    {instr_boundary, cnt, cpu_pc, cpu_flags} = '0;
    {stack_pc, stack_flags} = 16'h5a5a;
  end
  // Only PC and flags go on the stack; an empty stack shows a changing pattern.
  // Non-blocking drives keep the boundary in step with the divider after reset release.
  always @(posedge ref_clk) begin
    cnt <= srst ? 3'h0 : cnt + 3'h1;
    instr_boundary <= !srst && (cnt == 3'h6);
    if (!srst && cnt == 3'h6) begin
      cpu_pc <= cpu_pc + 12'h001;
      cpu_flags <= 4'($urandom);
    end
    if (push_req === 1'b1) stk.push_front({push_pc, push_flags});
    if (pop_req === 1'b1 && stk.size() > 0) void'(stk.pop_front());
    {stack_pc, stack_flags} <= (stk.size() > 0) ? stk[0] : ~{stack_pc, stack_flags};
  end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
  import pic_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        ext_irq_high = 1'b1;
  logic        ext_irq_low = 1'b1;
  logic        counter_a_overflow_irq = 1'b0;
  logic        counter_b_overflow_irq = 1'b0;
  logic        interval_tick_irq = 1'b0;
  logic        exchange_with_accumulator = 1'b0;
  logic        latch_clear = 1'b0;
  logic        latch_clear_with_enable = 1'b0;
  logic        latch_clear_with_disable = 1'b0;
  logic        return_from_service = 1'b0;
  logic [3:0]  acc_in = 4'h0;
  logic [5:0]  latch_keep_mask = 6'h3f;
  logic        instr_boundary, ack_busy, push_req, pc_load, flags_load, pop_req;
  logic        master_irq_enable;
  logic [3:0]  acc_out, cpu_flags, stack_flags, push_flags, flags_load_value, source_enable_mask;
  logic [11:0] cpu_pc, stack_pc, push_pc, pc_load_value;
  logic [5:0]  request_latch;
  logic [11:0] exp_q[$];
  logic [11:0] vt[5] = '{VEC_EXT_HIGH, VEC_CNT_A, VEC_CNT_B, VEC_TICK, VEC_EXT_LOW};
  int          idx[5] = '{5, 3, 2, 1, 0};
  int          miscompares = 0;
  int          tests_run = 0;
  logic [3:0]  prev;
  logic [5:0]  el;
  logic [5:0]  k;
  pic_ctrl pic_ctrl_inst (
    .ref_clk(ref_clk), .srst(srst), .ext_irq_high(ext_irq_high), .ext_irq_low(ext_irq_low),
    .counter_a_overflow_irq(counter_a_overflow_irq),
    .counter_b_overflow_irq(counter_b_overflow_irq),
    .interval_tick_irq(interval_tick_irq), .instr_boundary(instr_boundary),
    .exchange_with_accumulator(exchange_with_accumulator), .acc_in(acc_in),
    .latch_clear(latch_clear), .latch_clear_with_enable(latch_clear_with_enable),
    .latch_clear_with_disable(latch_clear_with_disable), .latch_keep_mask(latch_keep_mask),
    .return_from_service(return_from_service), .cpu_pc(cpu_pc), .cpu_flags(cpu_flags),
    .stack_pc(stack_pc), .stack_flags(stack_flags), .acc_out(acc_out), .ack_busy(ack_busy),
    .push_req(push_req), .push_pc(push_pc), .push_flags(push_flags), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .flags_load(flags_load),
    .flags_load_value(flags_load_value), .pop_req(pop_req),
    .master_irq_enable(master_irq_enable), .source_enable_mask(source_enable_mask),
    .request_latch(request_latch)
  );
  pic_cpu_model pic_cpu_model_inst (
    .ref_clk(ref_clk), .srst(srst), .push_req(push_req), .push_pc(push_pc),
    .push_flags(push_flags), .pop_req(pop_req), .instr_boundary(instr_boundary),
    .cpu_pc(cpu_pc), .cpu_flags(cpu_flags), .stack_pc(stack_pc), .stack_flags(stack_flags)
  );
  always #50 ref_clk = ~ref_clk;
  task automatic check(string n, logic [11:0] s, logic [11:0] e);
    tests_run++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic fire(ref logic s, input logic [5:0] km);
    latch_keep_mask = km;
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic wait_busy(logic v);
    int n;
    n = 0;
    while (ack_busy !== v) begin
      cyc(1);
      n++;
      if (n > 40) begin
        $display("ERROR ack_busy timeout");
        miscompares++;
        end_of_test();
      end
    end
  endtask
  always @(negedge ref_clk)
    if (pc_load === 1'b1 && pop_req !== 1'b1) begin
      check("entry", pc_load_value, (exp_q.size() > 0) ? exp_q.pop_front() : 12'hfff);
      check("branch_flag", {11'h0, flags_load_value[FLAG_BRANCH]}, 12'h001);
      check("ack_strobes", {10'h0, push_req, flags_load}, 12'h003);
    end
  initial begin
    void'($urandom(32'hdfc1));
    cyc(6);
    srst = 1'b0;
    cyc(1);
    check("reset", {1'b0, master_irq_enable, source_enable_mask, request_latch}, 12'h000);
    $display("test reset done");
    prev = 4'h0;
    for (int i = 0; i < 3; i++) begin
      acc_in = (i == 1) ? 4'($urandom) : 4'hf;
      fire(exchange_with_accumulator, 6'h3f);
      check("exchange", {4'h0, acc_out, source_enable_mask}, {4'h0, prev, acc_in});
      prev = acc_in;
    end
    $display("test exchange done");
    {ext_irq_high, ext_irq_low} = 2'h0;
    {counter_a_overflow_irq, counter_b_overflow_irq, interval_tick_irq} = 3'h7;
    cyc(1);
    {counter_a_overflow_irq, counter_b_overflow_irq, interval_tick_irq} = 3'h0;
    cyc(5);
    check("latched", {6'h0, request_latch}, 12'h02f);
    {ext_irq_high, ext_irq_low} = 2'h3;
    el = 6'h2f;
    for (int i = 0; i < 5; i++) begin
      exp_q.push_back(vt[i]);
      if (i == 0) fire(latch_clear_with_enable, 6'h3f);
      else fire(return_from_service, 6'h3f);
      wait_busy(1'b1);
      wait_busy(1'b0);
      cyc(1);
      el[idx[i]] = 1'b0;
      check("after_ack", {6'h0, request_latch}, {6'h0, el});
    end
    $display("test priority done");
    acc_in = 4'h0;
    fire(exchange_with_accumulator, 6'h3f);
    {counter_b_overflow_irq, interval_tick_irq} = 2'h3;
    cyc(1);
    {counter_b_overflow_irq, interval_tick_irq} = 2'h0;
    fire(return_from_service, 6'h3f);
    cyc(40);
    check("gated", {5'h0, master_irq_enable, request_latch}, 12'h046);
    exp_q.push_back(VEC_CNT_B);
    acc_in = 4'h2;
    fire(exchange_with_accumulator, 6'h3f);
    wait_busy(1'b1);
    wait_busy(1'b0);
    cyc(1);
    check("shared_bit", {6'h0, request_latch}, 12'h002);
    $display("test gating done");
    counter_a_overflow_irq = 1'b1;
    cyc(1);
    counter_a_overflow_irq = 1'b0;
    cyc(1);
    k = 6'($urandom);
    fire(latch_clear, k);
    check("clear", {6'h0, request_latch}, {6'h0, 6'h0a & k});
    fire(latch_clear_with_enable, 6'h00);
    check("clear_en", {5'h0, master_irq_enable, request_latch}, 12'h040);
    fire(latch_clear_with_disable, 6'h3f);
    check("clear_dis", {5'h0, master_irq_enable, request_latch}, 12'h000);
    $display("test latch ops done");
    end_of_test();
  end
endmodule
